// >>> pkg/fsu_pkg.sv
// shared constants and types of the flexible serial unit
package fsu_pkg;

    // register byte offsets on the avalon slave
    localparam logic [4:0] FSU_OFS_CTRL = 5'h00;
    localparam logic [4:0] FSU_OFS_STAT = 5'h04;
    localparam logic [4:0] FSU_OFS_DATA = 5'h08;
    localparam logic [4:0] FSU_OFS_PORT = 5'h0C;
    localparam logic [4:0] FSU_OFS_PINS = 5'h10;

    // serial_if_control fields
    localparam int FSU_CTRL_STRT_IE = 7;
    localparam int FSU_CTRL_OVF_IE = 6;
    localparam int FSU_CTRL_WM_LSB = 4;
    localparam int FSU_CTRL_CS_LSB = 2;
    localparam int FSU_CTRL_CLK = 1;
    localparam int FSU_CTRL_TGL = 0;

    // status fields
    localparam int FSU_STAT_START = 7;
    localparam int FSU_STAT_OVF = 6;
    localparam int FSU_STAT_CNT_LSB = 0;

    // pin indices inside port, direction and pins registers
    localparam int FSU_PIN_DOUT = 0;
    localparam int FSU_PIN_SDA = 1;
    localparam int FSU_PIN_SCL = 2;
    localparam int FSU_PORT_DDR_LSB = 4;

    // wire modes
    localparam logic [1:0] FSU_WM_OFF = 2'h0;
    localparam logic [1:0] FSU_WM_THREE = 2'h1;
    localparam logic [1:0] FSU_WM_TWO = 2'h2;
    localparam logic [1:0] FSU_WM_TWO_HOLD = 2'h3;

    // clock sources
    localparam logic [1:0] FSU_CS_SOFT = 2'h0;
    localparam logic [1:0] FSU_CS_TIMER = 2'h1;

    // reset values and counter maximum
    localparam logic [7:0] FSU_RST_CTRL = 8'h00;
    localparam logic [7:0] FSU_RST_DATA = 8'h00;
    localparam logic [2:0] FSU_RST_PORT = 3'h0;
    localparam logic [2:0] FSU_RST_DDR = 3'h0;
    localparam logic [3:0] FSU_RST_CNT = 4'h0;
    localparam logic [3:0] FSU_CNT_MAX = 4'hF;

    typedef enum logic [1:0] {
        FSU_BUS_IDLE = 2'b00,
        FSU_BUS_ACK = 2'b01
    } fsu_bus_e;

endpackage

// >>> logic/fsu_sync.sv
// two-flop synchroniser with edge detection for pin inputs
`timescale 1ns/1ps
module fsu_sync #(
    parameter int W = 2
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
        logic [W-1:0] prev;
    } fsu_sync_s;

    fsu_sync_s q;
    fsu_sync_s d;

    always_comb begin
        d = q;
        d.meta = pin_i;
        d.sync = q.meta;
        d.prev = q.sync;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            // idle bus lines sit high, so no false edge after reset
            q <= '1;
        end else begin
            q <= d;
        end
    end

    // edges look at the second and third stage only
    assign level = q.sync;
    assign rise = q.sync & ~q.prev;
    assign fall = ~q.sync & q.prev;
endmodule

// >>> logic/fsu_counter.sv
// four-bit step counter with load and wrap pulse
`timescale 1ns/1ps
module fsu_counter (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic step,
    input wire logic load,
    input wire logic [3:0] load_val,
    output logic [3:0] count,
    output logic wrap
);
    typedef struct packed {
        logic [3:0] cnt;
    } fsu_cnt_s;

    fsu_cnt_s q;
    fsu_cnt_s d;

    always_comb begin
        d = q;
        // a software load wins over a clock in the same cycle
        if (load) begin
            d.cnt = load_val;
        end else if (step) begin
            d.cnt = q.cnt + 4'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q.cnt <= fsu_pkg::FSU_RST_CNT;
        end else begin
            q <= d;
        end
    end

    assign count = q.cnt;
    // wrap on 15 to 0
    assign wrap = step & ~load & (q.cnt == fsu_pkg::FSU_CNT_MAX);
endmodule

// >>> logic/fsu_top.sv
// wire mode, clock source and pin logic of the flexible serial unit
`timescale 1ns/1ps
module fsu_top (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic timer_match,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    output logic dout_out,
    output logic dout_oe,
    output logic [2:0] pullup_en
);
    typedef struct packed {
        fsu_pkg::fsu_bus_e bus;
        logic [31:0] rdata;
        logic [7:0] ctrl;
        logic [7:0] sr;
        logic do_latch;
        logic latch_open;
        logic start_flag;
        logic ovf_flag;
        logic [2:0] port;
        logic [2:0] ddr;
    } fsu_top_s;

    fsu_top_s q;
    fsu_top_s d;

    logic [1:0] pin_level;
    logic [1:0] pin_rise;
    logic [1:0] pin_fall;
    logic sda_lvl;
    logic scl_lvl;
    logic scl_rise;
    logic scl_fall;
    logic scl_edge;
    logic sda_fall;

    logic [3:0] count;
    logic wrap;

    logic req;
    logic wr_go;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_data;
    logic wr_port;
    logic sw_strobe;
    logic tc_strobe;

    logic [1:0] wm;
    logic [1:0] cs;
    logic clk_sel;
    logic two_wire;

    logic timer_step;
    logic ext_shift_edge;
    logic ext_latch_edge;
    logic shift_step;
    logic cnt_step;
    logic start_set;
    logic clk_hold;
    logic dout_val;
    logic [31:0] read_mux;

    fsu_sync #(
        .W(2)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin_i({scl_in, sda_in}),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    assign sda_lvl = pin_level[0];
    assign scl_lvl = pin_level[1];
    assign sda_fall = pin_fall[0];
    assign scl_rise = pin_rise[1];
    assign scl_fall = pin_fall[1];
    assign scl_edge = scl_rise | scl_fall;

    // any status write reloads the counter
    fsu_counter u_counter (
        .clk_sys(clk_sys),
        .rst(rst),
        .step(cnt_step),
        .load(wr_stat),
        .load_val(avs_writedata[3:0]),
        .count(count),
        .wrap(wrap)
    );

    assign wm = q.ctrl[fsu_pkg::FSU_CTRL_WM_LSB +: 2];
    assign cs = q.ctrl[fsu_pkg::FSU_CTRL_CS_LSB +: 2];
    assign clk_sel = q.ctrl[fsu_pkg::FSU_CTRL_CLK];
    assign two_wire = wm[1];

    // one wait state: request seen, then answered next cycle
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & (q.bus != fsu_pkg::FSU_BUS_ACK);
    assign avs_readdata = q.rdata;

    // writes land only on the cycle waitrequest is low
    assign wr_go = avs_write & (q.bus == fsu_pkg::FSU_BUS_ACK) & avs_byteenable[0];
    assign wr_ctrl = wr_go & (avs_address == fsu_pkg::FSU_OFS_CTRL);
    assign wr_stat = wr_go & (avs_address == fsu_pkg::FSU_OFS_STAT);
    assign wr_data = wr_go & (avs_address == fsu_pkg::FSU_OFS_DATA);
    assign wr_port = wr_go & (avs_address == fsu_pkg::FSU_OFS_PORT);

    // strobe only with software source, taken from the same write
    assign sw_strobe = wr_ctrl & avs_writedata[fsu_pkg::FSU_CTRL_CLK]
        & (avs_writedata[fsu_pkg::FSU_CTRL_CS_LSB +: 2] == fsu_pkg::FSU_CS_SOFT);
    assign tc_strobe = wr_ctrl & avs_writedata[fsu_pkg::FSU_CTRL_TGL];

    // shift edge chosen by lower source bit
    assign ext_shift_edge = cs[1] & (cs[0] ? scl_fall : scl_rise);
    // output side uses the opposite edge
    assign ext_latch_edge = cs[1] & (cs[0] ? scl_rise : scl_fall);

    // timer match ignores the strobe bit
    assign timer_step = (cs == fsu_pkg::FSU_CS_TIMER) & timer_match;

    // every source is a single-cycle pulse, so one shift per event
    assign shift_step = sw_strobe
        | timer_step
        | ext_shift_edge;

    // both edges count unless the strobe bit selects toggle clocking
    // toggle strobe clocks the counter in external mode
    assign cnt_step = sw_strobe
        | timer_step
        | (cs[1] & ~clk_sel & scl_edge)
        | (cs[1] & clk_sel & tc_strobe);

    // start detection only in the two-wire modes
    // external clock edges still raise the flag outside the two-wire modes, in wire modes 00 and 01, unless toggle clocking is selected
    assign start_set = (two_wire & sda_fall & scl_lvl)
        | (~two_wire & cs[1] & ~clk_sel & scl_edge);

    // overflow hold only in mode 11
    // hold only bites with the clock driver enabled, gated below
    assign clk_hold = two_wire
        & (q.start_flag | ((wm == fsu_pkg::FSU_WM_TWO_HOLD) & q.ovf_flag));

    // internal sources see the msb directly
    always_comb begin
        if (cs[1]) begin
            dout_val = q.do_latch;
        end else begin
            dout_val = q.sr[7];
        end
    end

    always_comb begin
        read_mux = 32'h0000_0000;
        case (avs_address)
            fsu_pkg::FSU_OFS_CTRL: begin
                // strobe bits read back as zero
                read_mux[7:0] = {q.ctrl[7:2], 2'h0};
            end
            fsu_pkg::FSU_OFS_STAT: begin
                read_mux[fsu_pkg::FSU_STAT_START] = q.start_flag;
                read_mux[fsu_pkg::FSU_STAT_OVF] = q.ovf_flag;
                read_mux[fsu_pkg::FSU_STAT_CNT_LSB +: 4] = count;
            end
            fsu_pkg::FSU_OFS_DATA: begin
                read_mux[7:0] = q.sr;
            end
            fsu_pkg::FSU_OFS_PORT: begin
                read_mux[fsu_pkg::FSU_PORT_DDR_LSB +: 3] = q.ddr;
                read_mux[2:0] = q.port;
            end
            fsu_pkg::FSU_OFS_PINS: begin
                read_mux[fsu_pkg::FSU_PIN_SDA] = sda_lvl;
                read_mux[fsu_pkg::FSU_PIN_SCL] = scl_lvl;
            end
            default: begin
                read_mux = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        d = q;

        case (q.bus)
            fsu_pkg::FSU_BUS_IDLE: begin
                if (req) begin
                    d.bus = fsu_pkg::FSU_BUS_ACK;
                    d.rdata = read_mux;
                end
            end
            fsu_pkg::FSU_BUS_ACK: begin
                d.bus = fsu_pkg::FSU_BUS_IDLE;
            end
            default: begin
                d.bus = fsu_pkg::FSU_BUS_IDLE;
            end
        endcase

        // strobe bit kept as source select, toggle bit never stored
        if (wr_ctrl) begin
            d.ctrl = {avs_writedata[7:1], 1'b0};
        end

        // a write in the same cycle as a clock wins, no shift
        if (wr_data) begin
            d.sr = avs_writedata[7:0];
        end else if (shift_step) begin
            // synchronised input is the pin sample from two cycles back
            d.sr = {q.sr[6:0], sda_lvl};
        end

        // latch opens after the output edge, closes at sampling edge
        if (ext_latch_edge) begin
            d.latch_open = 1'b1;
            d.do_latch = q.sr[7];
        end else if (ext_shift_edge) begin
            d.latch_open = 1'b0;
        end else if (q.latch_open) begin
            d.do_latch = q.sr[7];
        end

        // set wins over a write-one clear
        if (wr_stat & avs_writedata[fsu_pkg::FSU_STAT_START]) begin
            d.start_flag = 1'b0;
        end
        if (start_set) begin
            d.start_flag = 1'b1;
        end
        // wrap sets overflow, again ahead of a clear
        if (wr_stat & avs_writedata[fsu_pkg::FSU_STAT_OVF]) begin
            d.ovf_flag = 1'b0;
        end
        if (wrap) begin
            d.ovf_flag = 1'b1;
        end

        if (wr_port) begin
            d.port = avs_writedata[2:0];
            d.ddr = avs_writedata[fsu_pkg::FSU_PORT_DDR_LSB +: 3];
        end
        // toggle strobe flips the clock port bit in any direction
        if (tc_strobe) begin
            d.port[fsu_pkg::FSU_PIN_SCL] = ~q.port[fsu_pkg::FSU_PIN_SCL];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q.bus <= fsu_pkg::FSU_BUS_IDLE;
            q.rdata <= 32'h0000_0000;
            q.ctrl <= fsu_pkg::FSU_RST_CTRL;
            q.sr <= fsu_pkg::FSU_RST_DATA;
            q.do_latch <= 1'b0;
            q.latch_open <= 1'b0;
            q.start_flag <= 1'b0;
            q.ovf_flag <= 1'b0;
            q.port <= fsu_pkg::FSU_RST_PORT;
            q.ddr <= fsu_pkg::FSU_RST_DDR;
        end else begin
            q <= d;
        end
    end

    always_comb begin
        // default is ordinary port behaviour on all three pins
        dout_out = q.port[fsu_pkg::FSU_PIN_DOUT];
        dout_oe = q.ddr[fsu_pkg::FSU_PIN_DOUT];
        sda_out = q.port[fsu_pkg::FSU_PIN_SDA];
        sda_oe = q.ddr[fsu_pkg::FSU_PIN_SDA];
        scl_out = q.port[fsu_pkg::FSU_PIN_SCL];
        scl_oe = q.ddr[fsu_pkg::FSU_PIN_SCL];
        pullup_en = ~q.ddr & q.port;

        case (wm)
            fsu_pkg::FSU_WM_OFF: begin
                // plain port pins, no serial drive
                dout_out = q.port[fsu_pkg::FSU_PIN_DOUT];
            end
            fsu_pkg::FSU_WM_THREE: begin
                // serial bit replaces the port bit
                dout_out = dout_val;
                // input and clock pins left as ports
                sda_out = q.port[fsu_pkg::FSU_PIN_SDA];
                sda_oe = q.ddr[fsu_pkg::FSU_PIN_SDA];
                scl_out = q.port[fsu_pkg::FSU_PIN_SCL];
                scl_oe = q.ddr[fsu_pkg::FSU_PIN_SCL];
            end
            fsu_pkg::FSU_WM_TWO, fsu_pkg::FSU_WM_TWO_HOLD: begin
                // data low on msb or port zero
                sda_out = 1'b0;
                sda_oe = q.ddr[fsu_pkg::FSU_PIN_SDA]
                    & (~dout_val | ~q.port[fsu_pkg::FSU_PIN_SDA]);
                // clock low on port zero or hold
                scl_out = 1'b0;
                scl_oe = q.ddr[fsu_pkg::FSU_PIN_SCL]
                    & (~q.port[fsu_pkg::FSU_PIN_SCL] | clk_hold);
                // no pull-ups on the bus lines
                pullup_en[fsu_pkg::FSU_PIN_SDA] = 1'b0;
                pullup_en[fsu_pkg::FSU_PIN_SCL] = 1'b0;
            end
            default: begin
                dout_out = q.port[fsu_pkg::FSU_PIN_DOUT];
            end
        endcase
    end
endmodule

// >>> testbench/fsu_top_assertions.sv
// port-level assertions of the flexible serial unit
`timescale 1ns/1ps
module fsu_top_assertions (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic timer_match,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic dout_out,
    input wire logic dout_oe,
    input wire logic [2:0] pullup_en
);
    logic [1:0] wm_q;
    logic [2:0] prt_q;
    logic [2:0] ddr_q;
    logic [1:0] st_q;
    logic acc, tw, w3, rdok;
    assign acc = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign rdok = avs_read && !avs_waitrequest;
    // pins settle a few cycles after the last write
    assign tw = wm_q[1] && st_q == 2'h3;
    assign w3 = wm_q == 2'h1 && st_q == 2'h3;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wm_q <= 2'h0;
            prt_q <= 3'h0;
            ddr_q <= 3'h0;
            st_q <= 2'h0;
        end else begin
            st_q <= acc ? 2'h0 : (st_q == 2'h3 ? st_q : st_q + 2'h1);
            if (acc && avs_address == fsu_pkg::FSU_OFS_CTRL) begin
                wm_q <= avs_writedata[5:4];
                prt_q[2] <= prt_q[2] ^ avs_writedata[0];
            end
            if (acc && avs_address == fsu_pkg::FSU_OFS_PORT) begin
                prt_q <= avs_writedata[2:0];
                ddr_q <= avs_writedata[6:4];
            end
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    chk_one_wait: assert property (($rose(avs_read) || $rose(avs_write)) |->
        avs_waitrequest ##1 !avs_waitrequest) else $error("wait state count wrong");
    chk_strobe_zero: assert property (rdok && avs_address == fsu_pkg::FSU_OFS_CTRL |->
        avs_readdata[1:0] == 2'h0) else $error("strobe bits read nonzero");
    chk_unmapped_zero: assert property (rdok && !(avs_address inside {5'h00, 5'h04, 5'h08,
        5'h0C, 5'h10}) |-> avs_readdata == 32'h0) else $error("unmapped read nonzero");
    chk_open_drain: assert property (tw && (sda_oe || scl_oe) |->
        !(sda_oe && sda_out) && !(scl_oe && scl_out)) else $error("line driven high");
    chk_drive_enable: assert property (tw && !ddr_q[1] |-> !sda_oe)
        else $error("data driver on without direction bit");
    chk_sda_low: assert property (tw && ddr_q[1] && !prt_q[1] |-> sda_oe && !sda_out)
        else $error("data line not pulled low");
    chk_scl_low: assert property (tw && ddr_q[2] && !prt_q[2] |-> scl_oe && !scl_out)
        else $error("clock line not pulled low");
    chk_pullup_off: assert property (tw |-> pullup_en[2:1] == 2'h0)
        else $error("pull-up left on in two-wire mode");
    chk_start_hold: assert property (tw && ddr_q[2] && $fell(sda_in) && scl_in |->
        ##[3:6] (scl_oe && !scl_out)) else $error("start did not hold clock");
    chk_three_pin: assert property (w3 |-> dout_oe == ddr_q[0] &&
        (ddr_q[0] || pullup_en[0] == prt_q[0])) else $error("three-wire pin control wrong");
    cover property (acc && avs_address == fsu_pkg::FSU_OFS_CTRL && avs_writedata[3:1] == 3'h1);
    cover property (tw && scl_oe && !scl_out && prt_q[2]);
    cover property (wm_q == 2'h3 && scl_oe && !scl_out && prt_q[2]);
endmodule
bind fsu_top fsu_top_assertions u_chk (.clk_sys(clk_sys), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .timer_match(timer_match), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .dout_out(dout_out),
    .dout_oe(dout_oe), .pullup_en(pullup_en));

// >>> testbench/fsu_link_partner.sv
// far-side serial bus device: sends one framed byte on request
`timescale 1ns/1ps
module fsu_link_partner (
    input wire logic go,
    input wire logic [7:0] tx,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic scl_out,
    input wire logic scl_oe,
    output logic sda_in,
    output logic scl_in,
    output logic done
);
    logic lclk = 1'b0;
    logic p_sda = 1'b1;
    logic p_scl = 1'b1;
    // own phase, unrelated to the system clock
    always #80 lclk = ~lclk;
    // wired-and lines with pull-up
    assign sda_in = p_sda & !(sda_oe && !sda_out);
    assign scl_in = p_scl & !(scl_oe && !scl_out);
    always @(posedge go) begin
        done = 1'b0;
        @(posedge lclk) p_sda = 1'b0;
        @(posedge lclk) p_scl = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            @(posedge lclk) p_sda = tx[i];
            @(posedge lclk) p_scl = 1'b1;
            wait (scl_in === 1'b1);
            @(posedge lclk) p_scl = 1'b0;
        end
        @(posedge lclk) p_sda = 1'b0;
        @(posedge lclk) p_scl = 1'b1;
        wait (scl_in === 1'b1);
        @(posedge lclk) p_sda = 1'b1;
        done = 1'b1;
    end
endmodule

// >>> testbench/fsu_top_tb.sv
// self-checking bench of the flexible serial unit
`timescale 1ns/1ps
module fsu_top_tb;
    localparam logic [4:0] a_ctl = fsu_pkg::FSU_OFS_CTRL;
    localparam logic [4:0] a_st = fsu_pkg::FSU_OFS_STAT;
    localparam logic [4:0] a_dat = fsu_pkg::FSU_OFS_DATA;
    localparam logic [4:0] a_prt = fsu_pkg::FSU_OFS_PORT;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, timer_match = 1'b0, go = 1'b0, done;
    logic sda_in, sda_out, sda_oe, scl_in, scl_out, scl_oe, dout_out, dout_oe;
    logic [2:0] pullup_en;
    logic [7:0] tx = 8'h00;
    logic [7:0] rq, ex;
    logic [31:0] rnd = 32'h1D2A7CFB;
    logic [4:0] ra [6] = '{a_ctl, a_st, a_dat, a_prt, fsu_pkg::FSU_OFS_PINS, 5'h14};
    int miscompares = 0;
    int num_checks = 0;
    int cyc = 0;
    always #10 clk_sys = ~clk_sys;
    fsu_top DUT (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .timer_match(timer_match), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe(sda_oe), .scl_in(scl_in), .scl_out(scl_out),
        .scl_oe(scl_oe), .dout_out(dout_out), .dout_oe(dout_oe), .pullup_en(pullup_en));
    fsu_link_partner PRT (.go(go), .tx(tx), .sda_out(sda_out), .sda_oe(sda_oe),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .scl_in(scl_in), .done(done));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one avalon access; read data lands in rq
    task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
        logic wt;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= !w;
        // waitrequest and read data are taken at the same rising edge
        do begin
            @(posedge clk_sys);
            wt = avs_waitrequest;
            rq = avs_readdata[7:0];
        end while (wt !== 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            timer_match <= 1'b1;
            @(posedge clk_sys);
            timer_match <= 1'b0;
            @(posedge clk_sys);
        end
    endtask
    // m: 0 no hold, 1 start hold, 2 start and overflow hold
    task automatic frame(input logic [7:0] t, input int m);
        // let the pins settle after the last register write
        repeat (3) @(posedge clk_sys);
        tx <= t;
        go <= 1'b1;
        if (m > 0) wait (scl_oe === 1'b1);
        @(posedge clk_sys);
        go <= 1'b0;
        if (m > 0) begin
            repeat (8) @(posedge clk_sys);
            chk(scl_oe & ~scl_out, 1'b1);
            acc(1'b1, a_st, 8'h80);
            repeat (2) @(posedge clk_sys);
            chk(scl_oe, 1'b0);
        end
        if (m > 1) begin
            wait (scl_oe === 1'b1);
            chk(done, 1'b0);
            repeat (8) @(posedge clk_sys);
            chk(scl_oe & ~scl_out, 1'b1);
            acc(1'b1, a_st, 8'h40);
        end
        wait (done === 1'b1);
        @(posedge clk_sys);
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        foreach (ra[i]) begin
            acc(1'b0, ra[i], 8'h00);
            chk(rq, i == 4 ? 8'h06 : 8'h00);
        end
        avs_byteenable <= 4'hE;
        acc(1'b1, a_dat, 8'hFF);
        avs_byteenable <= 4'hF;
        acc(1'b0, a_dat, 8'h00);
        chk(rq, 8'h00);
        repeat (4) begin
            rnd = lfsr(rnd);
            acc(1'b1, a_ctl, rnd[7:0]);
            acc(1'b0, a_ctl, 8'h00);
            chk(rq, rnd[7:0] & 8'hFC);
        end
        acc(1'b1, a_prt, 8'h11);
        rnd = lfsr(rnd);
        ex = rnd[7:0];
        acc(1'b1, a_dat, ex);
        acc(1'b1, a_st, 8'hC0);
        repeat (16) begin
            acc(1'b1, a_ctl, 8'h12);
            ex = {ex[6:0], 1'b1};
            @(negedge clk_sys);
            chk(dout_out, ex[7]);
            @(posedge clk_sys);
        end
        acc(1'b0, a_dat, 8'h00);
        chk(rq, ex);
        acc(1'b0, a_st, 8'h00);
        chk(rq, 8'h40);
        // strobe ignored outside source 00, timer only in 01
        acc(1'b1, a_ctl, 8'h10);
        acc(1'b1, a_ctl, 8'h16);
        tick(3);
        acc(1'b1, a_ctl, 8'h10);
        tick(2);
        acc(1'b0, a_st, 8'h00);
        chk(rq, 8'h43);
        acc(1'b1, a_prt, 8'h06);
        for (int k = 0; k < 2; k++) begin
            acc(1'b1, a_ctl, k ? 8'h1A : 8'h18);
            acc(1'b1, a_st, 8'hC0);
            rnd = lfsr(rnd);
            frame(rnd[7:0], 0);
            acc(1'b0, a_dat, 8'h00);
            chk(rq, {rnd[6:0], 1'b0});
            repeat (3) acc(1'b1, a_ctl, k ? 8'h1B : 8'h19);
            acc(1'b0, a_st, 8'h00);
            chk(rq & 8'h7F, k ? 8'h03 : 8'h42);
        end
        acc(1'b1, a_prt, 8'h22);
        acc(1'b1, a_ctl, 8'h20);
        for (int k = 0; k < 3; k++) begin
            acc(1'b1, k == 2 ? a_prt : a_dat, k == 2 ? 8'h60 : {k[0], 7'h00});
            @(negedge clk_sys);
            chk(sda_in, k == 1);
            @(posedge clk_sys);
        end
        for (int k = 0; k < 2; k++) begin
            acc(1'b1, a_st, 8'hC0);
            acc(1'b1, a_prt, 8'h46);
            acc(1'b1, a_dat, 8'hFF);
            acc(1'b1, a_ctl, k ? 8'h38 : 8'h28);
            rnd = lfsr(rnd);
            frame(rnd[7:0], k + 1);
            acc(1'b0, a_dat, 8'h00);
            chk(rq, {rnd[6:0], 1'b0});
            acc(1'b0, a_st, 8'h00);
            chk(rq & 8'h7F, k ? 8'h01 : 8'h41);
        end
        final_report();
    end
endmodule
